// ==== shared/sdl_pkg.sv ====
// What this block does
// - Take 16-bit word, sample data on falling clock
// - Link is clock, data, frame and load strobe
// - Latch updates automatically or by load strobe
// - Strobe low: update on sixteenth falling edge
// - Format low unipolar: natural binary code
// - Format high: two's complement code
// - Format low bipolar: offset binary, MSB inverted
// - Host frames transfer, releases frame when done
// - Active-high host frame must be inverted
// - Host may pulse load strobe for updates
// - Host sends 16-bit words, gated clock
// - Drop first four bits, twelve code bits MSB-first
// - Ignore clock edges after sixteen in frame
// - Strobe high at frame start: strobe-driven update
package sdl_pkg;
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int DONT_CARE_BITS = 4;
  localparam int CNT_W = 5;
  localparam int CLK_HZ = 10_000_000;
  localparam int SCLK_PERIOD_NS = 800;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int SCLK_HALF_CYC = (SCLK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CODE_BITS-1:0] LATCH_RST = 12'h000;
  localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
endpackage

// ==== shared/sdl_link_if.sv ====
interface sdl_link_if;
  logic shift_clk;
  logic serial_data_in;
  logic host_transmit_frame_n;
  logic latch_load_strobe_n;
  modport dac (
    input shift_clk,
    input serial_data_in,
    input host_transmit_frame_n,
    input latch_load_strobe_n
  );
  modport host (
    output shift_clk,
    output serial_data_in,
    output host_transmit_frame_n,
    output latch_load_strobe_n
  );
endinterface

// ==== design/sdl_dac_end.sv ====
module sdl_dac_end (
  input wire logic ref_clk,
  input wire logic rst,
  sdl_link_if.dac link,
  input wire logic code_format_select,
  input wire logic bipolar_range,
  output logic [sdl_pkg::CODE_BITS-1:0] dac_code,
  output logic [sdl_pkg::CODE_BITS-1:0] dac_code_offset,
  output logic dac_update
);
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic clk_d;
    logic ld_d;
    logic fr_d;
    logic busy;
    logic auto_mode;
    logic word_done;
    logic [sdl_pkg::CNT_W-1:0] cnt;
    logic [sdl_pkg::WORD_BITS-1:0] shreg;
    logic [sdl_pkg::CODE_BITS-1:0] code;
    logic [sdl_pkg::CODE_BITS-1:0] offs;
    logic upd;
  } sdl_dac_st_t;

  sdl_dac_st_t st_ff, nxt_st;
  logic clk_s, dat_s, fr_s, ld_s;

  assign clk_s = st_ff.s2[0];
  assign dat_s = st_ff.s2[1];
  assign fr_s = st_ff.s2[2];
  assign ld_s = st_ff.s2[3];

  // Natural or two's complement pass through; offset view flips MSB
  function automatic logic [sdl_pkg::CODE_BITS-1:0] flip_msb(input logic [sdl_pkg::CODE_BITS-1:0] c);
    flip_msb = {~c[sdl_pkg::CODE_BITS-1], c[sdl_pkg::CODE_BITS-2:0]};
  endfunction

  always_comb begin
    logic [sdl_pkg::WORD_BITS-1:0] w;
    logic [sdl_pkg::CODE_BITS-1:0] c;
    w = '0;
    c = '0;
    nxt_st = st_ff;
    nxt_st.upd = 1'b0;
    nxt_st.s1 = {link.latch_load_strobe_n, link.host_transmit_frame_n, link.serial_data_in, link.shift_clk};
    nxt_st.s2 = st_ff.s1;
    nxt_st.clk_d = clk_s;
    nxt_st.ld_d = ld_s;
    nxt_st.fr_d = fr_s;
    if (st_ff.fr_d && !fr_s) begin
      nxt_st.busy = 1'b1;
      nxt_st.cnt = sdl_pkg::CNT_RST;
      nxt_st.auto_mode = !ld_s;
      nxt_st.word_done = 1'b0;
    end else if (st_ff.busy && fr_s) begin
      nxt_st.busy = 1'b0;
    end else if (st_ff.busy && st_ff.clk_d && !clk_s &&
                 st_ff.cnt < 5'(sdl_pkg::WORD_BITS)) begin
      w = {st_ff.shreg[sdl_pkg::WORD_BITS-2:0], dat_s};
      nxt_st.shreg = w;
      nxt_st.cnt = st_ff.cnt + 5'h01;
      if (st_ff.cnt == 5'(sdl_pkg::WORD_BITS - 1)) begin
        nxt_st.word_done = 1'b1;
        if (st_ff.auto_mode) begin
          nxt_st.upd = 1'b1;
        end
      end
    end
    c = nxt_st.upd ? w[sdl_pkg::CODE_BITS-1:0] : st_ff.shreg[sdl_pkg::CODE_BITS-1:0];
    // strobe-driven update
    // Strobe dropping with the next frame edge selects auto mode, not a reload
    if (!st_ff.auto_mode && st_ff.word_done && st_ff.ld_d && !ld_s && !(st_ff.fr_d && !fr_s)) begin
      nxt_st.upd = 1'b1;
    end
    if (nxt_st.upd) begin
      nxt_st.code = c;
      if (bipolar_range && !code_format_select) begin
        nxt_st.offs = c;
        nxt_st.code = flip_msb(c);
      end else begin
        nxt_st.offs = flip_msb(c);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      // Pin idle levels, so no false edge follows reset
      st_ff <= '{s1: 4'h4, s2: 4'h4, clk_d: 1'b0, ld_d: 1'b0, fr_d: 1'b1, busy: 1'b0,
                 auto_mode: 1'b0, word_done: 1'b0, cnt: sdl_pkg::CNT_RST, shreg: 16'h0000,
                 code: sdl_pkg::LATCH_RST, offs: sdl_pkg::LATCH_RST, upd: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dac_code = st_ff.code;
  assign dac_code_offset = st_ff.offs;
  assign dac_update = st_ff.upd;
endmodule

// ==== design/sdl_host_end.sv ====
module sdl_host_end #(
  parameter int HALF_CYC = sdl_pkg::SCLK_HALF_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  sdl_link_if.host link,
  input wire logic send_req,
  input wire logic [sdl_pkg::WORD_BITS-1:0] send_word,
  input wire logic use_strobe,
  output logic send_busy,
  output logic send_done
);
  // Below two the far end's synchroniser can miss a clock phase
  if (HALF_CYC < 2 || HALF_CYC > 255) begin : g_half_chk
    $error("HALF_CYC out of range");
  end

  typedef enum logic [2:0] {IDLE, FRAME, HI, LO, END, STROBE} sdl_hst_e_t;
  typedef struct packed {
    sdl_hst_e_t st;
    logic [7:0] div;
    logic [sdl_pkg::CNT_W-1:0] bits;
    logic [sdl_pkg::WORD_BITS-1:0] sh;
    logic strobe_mode;
    logic sclk;
    logic sdat;
    logic fr_n;
    logic ld_n;
    logic busy;
    logic done;
  } sdl_hst_st_t;

  sdl_hst_st_t st_ff, nxt_st;
  logic tick;
  assign tick = st_ff.div == 8'(HALF_CYC - 1);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.div = (tick || st_ff.st == IDLE) ? 8'h00 : st_ff.div + 8'h01;
    case (st_ff.st)
      IDLE: begin
        if (send_req) begin
          nxt_st.sh = send_word;
          nxt_st.strobe_mode = use_strobe;
          nxt_st.ld_n = use_strobe;
          nxt_st.fr_n = 1'b0;
          nxt_st.busy = 1'b1;
          nxt_st.bits = sdl_pkg::CNT_RST;
          nxt_st.st = FRAME;
        end
      end
      FRAME: if (tick) begin
        nxt_st.sdat = st_ff.sh[sdl_pkg::WORD_BITS-1];
        nxt_st.sclk = 1'b1;
        nxt_st.st = HI;
      end
      HI: if (tick) begin
        nxt_st.sclk = 1'b0;
        nxt_st.sh = {st_ff.sh[sdl_pkg::WORD_BITS-2:0], 1'b0};
        nxt_st.bits = st_ff.bits + 5'h01;
        nxt_st.st = (st_ff.bits == 5'(sdl_pkg::WORD_BITS - 1)) ? END : LO;
      end
      LO: if (tick) begin
        nxt_st.sdat = st_ff.sh[sdl_pkg::WORD_BITS-1];
        nxt_st.sclk = 1'b1;
        nxt_st.st = HI;
      end
      END: if (tick) begin
        nxt_st.fr_n = 1'b1;
        if (st_ff.strobe_mode) begin
          nxt_st.ld_n = 1'b0;
          nxt_st.st = STROBE;
        end else begin
          nxt_st.busy = 1'b0;
          nxt_st.done = 1'b1;
          nxt_st.st = IDLE;
        end
      end
      STROBE: if (tick) begin
        nxt_st.ld_n = 1'b1;
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
        nxt_st.st = IDLE;
      end
      default: nxt_st.st = IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{st: IDLE, div: 8'h00, bits: sdl_pkg::CNT_RST, sh: 16'h0000, strobe_mode: 1'b0,
                 sclk: 1'b0, sdat: 1'b0, fr_n: 1'b1, ld_n: 1'b0, busy: 1'b0, done: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.shift_clk = st_ff.sclk;
  assign link.serial_data_in = st_ff.sdat;
  assign link.host_transmit_frame_n = st_ff.fr_n;
  assign link.latch_load_strobe_n = st_ff.ld_n;
  assign send_busy = st_ff.busy;
  assign send_done = st_ff.done;
endmodule

// ==== test/sdl_link_asserts.sv ====
module sdl_link_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic shift_clk,
  input wire logic serial_data_in,
  input wire logic host_transmit_frame_n,
  input wire logic latch_load_strobe_n
);
  logic [4:0] cnt_ff;
  // Falls per frame, cleared at frame start
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) cnt_ff <= 5'h00;
    else if ($fell(host_transmit_frame_n)) cnt_ff <= 5'h00;
    else if ($fell(shift_clk)) cnt_ff <= cnt_ff + 5'h01;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence hi2;
    shift_clk [*2];
  endsequence
  sequence lo2;
    !shift_clk [*2];
  endsequence
  // Auto-mode strobe drop rides on the frame edge
  sequence strb_fall;
    $fell(latch_load_strobe_n) && !$fell(host_transmit_frame_n);
  endsequence
  gated_clk_a: assert property (host_transmit_frame_n |-> !shift_clk)
    else $error("clock outside frame");
  data_hold_a: assert property ($fell(shift_clk) |-> $stable(serial_data_in))
    else $error("data moved");
  frame_start_a: assert property ($fell(host_transmit_frame_n) |-> !shift_clk)
    else $error("frame opened late");
  clk_high_a: assert property ($rose(shift_clk) |-> hi2)
    else $error("high too short");
  clk_low_a: assert property ($fell(shift_clk) |-> lo2)
    else $error("low too short");
  word_len_a: assert property ($rose(host_transmit_frame_n) |-> cnt_ff == 5'h10)
    else $error("word not 16 bits");
  no_extra_a: assert property ($fell(shift_clk) |-> cnt_ff < 5'h10)
    else $error("extra clock");
  strobe_late_a: assert property (strb_fall |-> cnt_ff == 5'h10)
    else $error("strobe early");
  strobe_pulse_a: assert property (strb_fall |-> !latch_load_strobe_n [*2])
    else $error("strobe pulse short");
endmodule

// ==== test/tb_serial_dac_input_loader.sv ====
module tb_serial_dac_input_loader;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic strb;
    logic fmt;
    logic bip;
    logic [15:0] word;
    logic [11:0] exp;
  } sdl_row_t;
  sdl_row_t rows [6] = '{
    '{1'b0, 1'b0, 1'b0, 16'hffff, 12'hfff},
    '{1'b0, 1'b0, 1'b0, 16'hf000, 12'h000},
    '{1'b1, 1'b1, 1'b1, 16'h07ff, 12'h7ff},
    '{1'b0, 1'b1, 1'b1, 16'h0800, 12'h800},
    '{1'b1, 1'b0, 1'b1, 16'ha800, 12'h000},
    '{1'b0, 1'b0, 1'b1, 16'h5123, 12'h923}
  };
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic send_req = 1'b0;
  logic [15:0] send_word = 16'h0000;
  logic use_strobe = 1'b0;
  logic code_format_select = 1'b0;
  logic bipolar_range = 1'b0;
  logic send_busy;
  logic send_done;
  logic [11:0] dac_code;
  logic [11:0] dac_code_offset;
  logic dac_update;
  int n_fail = 0;
  int num_checks = 0;
  sdl_link_if link ();
  sdl_host_end #(.HALF_CYC(4)) sdl_host_end_inst (.ref_clk, .rst, .link(link.host), .send_req, .send_word,
    .use_strobe, .send_busy, .send_done);
  sdl_dac_end sdl_dac_end_inst (.ref_clk, .rst, .link(link.dac), .code_format_select, .bipolar_range, .dac_code,
    .dac_code_offset, .dac_update);
  sdl_link_asserts sdl_link_asserts_inst (.ref_clk, .rst, .shift_clk(link.shift_clk),
    .serial_data_in(link.serial_data_in), .host_transmit_frame_n(link.host_transmit_frame_n),
    .latch_load_strobe_n(link.latch_load_strobe_n));
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Extra asks a second send mid-frame, which must be ignored
  task automatic run(input sdl_row_t r, input logic extra);
    int ups;
    logic got;
    ups = 0;
    got = 1'b0;
    @(posedge ref_clk);
    send_req <= 1'b1;
    send_word <= r.word;
    use_strobe <= r.strb;
    code_format_select <= r.fmt;
    bipolar_range <= r.bip;
    for (int i = 0; i < 400; i++) begin
      @(posedge ref_clk);
      send_req <= extra && i == 20;
      if (extra) send_word <= 16'h0fff;
      #1;
      ups += int'(dac_update === 1'b1);
      if (i == 20) chk(12'(send_busy), 12'h001);
      // Run on past done so a stray second update is counted
      if (send_done === 1'b1) begin
        got = 1'b1;
        i = 390;
      end
    end
    if (!got) begin
      n_fail++;
      finish_test();
    end
    chk(dac_code, r.exp);
    chk(dac_code_offset, r.exp ^ 12'h800);
    chk(12'(ups), 12'h001);
    chk(12'(send_busy), 12'h000);
    chk(12'(link.host_transmit_frame_n), 12'h001);
    chk(12'(link.latch_load_strobe_n), 12'(r.strb));
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(dac_code, 12'h000);
    foreach (rows[k]) run(rows[k], 1'b0);
    run('{1'b0, 1'b0, 1'b0, 16'h0123, 12'h123}, 1'b1);
    // Reset in mid-frame must drop the half-sent word
    @(posedge ref_clk);
    send_req <= 1'b1;
    send_word <= 16'h0456;
    @(posedge ref_clk);
    send_req <= 1'b0;
    repeat (40) @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk(dac_code, 12'h000);
    chk(dac_code_offset, 12'h000);
    chk(12'(dac_update), 12'h000);
    chk(12'(send_busy), 12'h000);
    chk(12'(link.host_transmit_frame_n), 12'h001);
    chk(12'(link.shift_clk), 12'h000);
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    run(rows[5], 1'b0);
    finish_test();
  end
endmodule
